//--- core/bwp_pkg.sv
package bwp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] BWP_OFS_PW_CTRL = 8'h00;
    localparam logic [7:0] BWP_OFS_GUARD = 8'h04;

    // ------------------------------------------------------------
    // Field layout of protection_password_control
    // ------------------------------------------------------------
    localparam int BWP_MODE_LSB = 0;
    localparam int BWP_MODE_MSB = 1;
    localparam int BWP_STAT_BIT = 2;
    localparam int BWP_PASS_LSB = 3;
    localparam int BWP_PASS_MSB = 7;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] BWP_MODE_OFF = 2'h0;
    localparam logic [1:0] BWP_MODE_RST = 2'h3;
    localparam logic [4:0] BWP_PASS_MODE_KEY = 5'h18;
    localparam logic [4:0] BWP_PASS_OPEN = 5'h13;
    localparam logic [4:0] BWP_PASS_CLOSE = 5'h15;
    localparam logic BWP_STAT_RST = 1'b1;
    localparam logic [7:0] BWP_GUARD_RST = 8'h00;
    localparam logic [31:0] BWP_RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Access state of the guarded bits
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BWP_ST_CLOSED = 2'b01,
        BWP_ST_OPEN = 2'b10
    } bwp_state_t;

endpackage : bwp_pkg

//--- core/bwp_guard_reg.sv
`timescale 1ns/1ps
`default_nettype none

module bwp_guard_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_req,
    input wire logic locked,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value
);

    // ------------------------------------------------------------
    // Guarded storage
    // ------------------------------------------------------------
    // Locked writes vanish without an error, so software must read back
    wire accept = wr_req & ~locked;
    logic [WIDTH-1:0] value_q;
    wire [WIDTH-1:0] value_d = accept ? wr_data : value_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            value_q <= RESET_VAL;
        else
            value_q <= value_d;
    end

    assign value = value_q;

endmodule : bwp_guard_reg

`default_nettype wire

//--- core/bwp_lock.sv
// Overview of operation
// - Control field 00 disables protection; guarded bits writable without password.
// - Control 11 (reset) or any non-00 keeps protection active.
// - Control changes only by a write carrying key 11000 in password field.
// - Password 10011 opens write access to all guarded bits.
// - Password 10101 closes write access to all guarded bits.
// - Any other password value does nothing.
// - Status bit 2 reads 0 when writable, 1 when blocked.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bwp_lock
    import bwp_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int GUARD_W = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic PROTECT,
    output logic [GUARD_W-1:0] GUARD_BITS
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] ofs
    );
        logic [ADDR_W-1:0] full;
        full = ADDR_W'(ofs);
        return addr[ADDR_W-1:2] == full[ADDR_W-1:2];
    endfunction : reg_hit

    // Exact five-bit match; a near miss never counts as a key
    function automatic logic pass_match(
        input logic [4:0] field,
        input logic [4:0] key
    );
        return field == key;
    endfunction : pass_match

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    bwp_state_t state_q;
    bwp_state_t state_d;
    logic protect_q;
    logic protect_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic [GUARD_W-1:0] guard_val;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE;
    wire done = access & pready_q;
    wire hit_pw = reg_hit(PADDR, BWP_OFS_PW_CTRL);
    wire hit_guard = reg_hit(PADDR, BWP_OFS_GUARD);
    wire hit_any = hit_pw | hit_guard;
    // Unmapped addresses answer with an error, still in one cycle
    wire miss = setup & ~hit_any;
    wire wr_done = done & PWRITE;
    // Only byte lane 0 carries register bits; other lanes are ignored
    wire wr_lane0 = wr_done & PSTRB[0];
    wire pw_wr = wr_lane0 & hit_pw;
    wire guard_wr = wr_lane0 & hit_guard;

    // ------------------------------------------------------------
    // Password decode
    // ------------------------------------------------------------
    wire [4:0] pass_in = PWDATA[BWP_PASS_MSB:BWP_PASS_LSB];
    wire [1:0] mode_in = PWDATA[BWP_MODE_MSB:BWP_MODE_LSB];
    // Unknown patterns match none of these and so leave all state alone
    wire key_mode = pw_wr & pass_match(pass_in, BWP_PASS_MODE_KEY);
    wire key_open = pw_wr & pass_match(pass_in, BWP_PASS_OPEN);
    wire key_close = pw_wr & pass_match(pass_in, BWP_PASS_CLOSE);

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    // Plain writes never reach the mode; only the key write loads it
    assign mode_d = key_mode ? mode_in : mode_q;

    // ------------------------------------------------------------
    // Open / closed state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BWP_ST_CLOSED:
            begin
                if (key_open)
                    state_d = BWP_ST_OPEN;
            end
            BWP_ST_OPEN:
            begin
                if (key_close)
                    state_d = BWP_ST_CLOSED;
            end
            default:
            begin
                // Corrupted code falls back to the safe side
                state_d = BWP_ST_CLOSED;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Protection status
    // ------------------------------------------------------------
    // Scheme off: always writable; scheme on: writable only while open
    wire scheme_on = mode_d != BWP_MODE_OFF;
    wire opened = state_d == BWP_ST_OPEN;
    assign protect_d = scheme_on & ~opened;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Password field is write-only and reads as zero
    wire [31:0] pw_read = {24'h00_0000, 5'h00, protect_q, mode_q};
    wire [31:0] guard_read = {{(32 - GUARD_W){1'b0}}, guard_val};
    wire [31:0] rd_sel_guard = hit_guard ? guard_read : BWP_RDATA_RST;
    assign rdata_d = hit_pw ? pw_read : rd_sel_guard;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Every piece of lock state resets to the locked side
    always_ff @(posedge CLK)
    begin
        if (RST)
            mode_q <= BWP_MODE_RST;
        else
            mode_q <= mode_d;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            state_q <= BWP_ST_CLOSED;
        else
            state_q <= state_d;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            protect_q <= BWP_STAT_RST;
        else
            protect_q <= protect_d;
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One wait-free access cycle; data sampled in setup, stable since
    // no write can land between setup and access of the same transfer
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= miss;
        end
    end

    // Read data held until the next setup
    always_ff @(posedge CLK)
    begin
        if (RST)
            prdata_q <= BWP_RDATA_RST;
        else if (setup)
            prdata_q <= rdata_d;
    end

    // ------------------------------------------------------------
    // Guarded bits
    // ------------------------------------------------------------
    bwp_guard_reg #(
        .WIDTH(GUARD_W),
        .RESET_VAL(GUARD_W'(BWP_GUARD_RST))
    ) u_guard (
        .clk(CLK),
        .rst(RST),
        .wr_req(guard_wr),
        .locked(protect_q),
        .wr_data(PWDATA[GUARD_W-1:0]),
        .value(guard_val)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PROTECT = protect_q;
    assign GUARD_BITS = guard_val;

endmodule : bwp_lock

`default_nettype wire

//--- sim/bwp_lock_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// --
// Lock checker
// --
module bwp_chk
    import bwp_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int GUARD_W = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PROTECT,
    input wire logic [GUARD_W-1:0] GUARD_BITS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic ctl = PADDR[ADDR_W-1:2] == 0;
    wire logic grd = PADDR[ADDR_W-1:2] == 1;
    wire logic [4:0] pw = PWDATA[7:3];
    wire logic odd = pw != BWP_PASS_MODE_KEY && pw != BWP_PASS_OPEN && pw != BWP_PASS_CLOSE;
    sequence s_set; PSEL && !PENABLE; endsequence
    sequence s_wr; PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]; endsequence
    property p_ready; s_set |=> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_open; s_wr ##0 (ctl && pw == BWP_PASS_OPEN) |=> !PROTECT; endproperty
    a_open: assert property (p_open) else $error("open left lock set");
    property p_off; s_wr ##0 (ctl && pw == BWP_PASS_MODE_KEY && PWDATA[1:0] == 2'h0) |=> !PROTECT; endproperty
    a_off: assert property (p_off) else $error("mode off left lock set");
    property p_odd; s_wr ##0 (ctl && odd) |=> $stable(PROTECT); endproperty
    a_odd: assert property (p_odd) else $error("unknown code acted");
    // Any lock change needs a write cycle
    property p_quiet; !(PSEL && PENABLE && PWRITE) |=> $stable(PROTECT) && $stable(GUARD_BITS); endproperty
    a_quiet: assert property (p_quiet) else $error("state moved without write");
    property p_lock; s_wr ##0 (grd && PROTECT) |=> $stable(GUARD_BITS); endproperty
    a_lock: assert property (p_lock) else $error("locked write landed");
    property p_gwr; s_wr ##0 (grd && !PROTECT) |=> GUARD_BITS == $past(PWDATA[GUARD_W-1:0]); endproperty
    a_gwr: assert property (p_gwr) else $error("open write lost");
    property p_stat; PREADY && !PWRITE && ctl |-> PRDATA[2] == PROTECT && PRDATA[31:3] == 0; endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_close; s_wr ##0 (ctl && pw == BWP_PASS_CLOSE && PROTECT) |=> PROTECT; endproperty
    a_close: assert property (p_close) else $error("close code opened lock");
    property p_err; s_set ##0 !(ctl || grd) |=> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("unmapped access gave no error");
endmodule : bwp_chk
bind bwp_lock bwp_chk #(.ADDR_W(ADDR_W), .GUARD_W(GUARD_W)) i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PROTECT(PROTECT), .GUARD_BITS(GUARD_BITS));
`default_nettype wire

//--- sim/bit_write_protection_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bit_write_protection_lock_tb;
    import bwp_pkg::*;
    localparam logic [7:0] CTL_A = BWP_OFS_PW_CTRL;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, open = 1'b0;
    logic [7:0] paddr = 8'h00, grd = 8'h00, a;
    logic [31:0] pwdata = 32'h0, rdata, r, d;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] mode = 2'h3;
    logic [4:0] pw;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, protect;
    wire logic [7:0] guard_bits;
    int fails = 0, n_checks = 0;
    always #5 clk = ~clk;
    bwp_lock i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PROTECT(protect),
        .GUARD_BITS(guard_bits));
    // --
    // Model and helpers
    // --
    function automatic logic prot();
        return mode != BWP_MODE_OFF && !open;
    endfunction : prot
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // Request held until the rising edge that samples ready; only the watchdog ends a wait
    task automatic op(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(err, ad != CTL_A && ad != BWP_OFS_GUARD);
        if (!w) chk(rdata, ad == CTL_A ? {29'h0, prot(), mode} : ad == BWP_OFS_GUARD ? {24'h0, grd} : 32'h0);
        if (w && s[0] && ad == CTL_A)
        begin
            if (dt[7:3] == BWP_PASS_MODE_KEY) mode = dt[1:0];
            if (dt[7:3] == BWP_PASS_OPEN) open = 1'b1;
            if (dt[7:3] == BWP_PASS_CLOSE) open = 1'b0;
        end
        if (w && s[0] && ad == BWP_OFS_GUARD && !prot()) grd = dt[7:0];
        @(negedge clk);
        chk(protect, prot());
        chk(guard_bits, grd);
    endtask : op
    // --
    // Tests
    // --
    initial
    begin
        void'($urandom(78));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        op(0, CTL_A, 0, 4'hF);
        op(1, CTL_A, 32'h0, 4'hF);
        op(1, BWP_OFS_GUARD, 32'hA5, 4'hF);
        op(1, CTL_A, {24'h0, BWP_PASS_MODE_KEY, 3'h0}, 4'hE);
        op(0, 8'h08, 0, 4'hF);
        $display("test corners done");
        for (int m = 0; m < 4; m++)
        begin
            op(1, CTL_A, {24'h0, BWP_PASS_MODE_KEY, 1'b0, 2'(m)}, 4'hF);
            op(1, BWP_OFS_GUARD, $urandom, 4'hF);
            op(1, CTL_A, {24'h0, m[0] ? BWP_PASS_OPEN : BWP_PASS_CLOSE, 3'h3}, 4'hF);
            op(0, CTL_A, 0, 4'hF);
        end
        $display("test modes done");
        for (int i = 0; i < 80; i++)
        begin
            r = $urandom;
            d = $urandom;
            a = r[8] ? BWP_OFS_GUARD : CTL_A;
            if (r[10:9] == 2'h0) a = 8'h10;
            pw = r[1:0] == 0 ? BWP_PASS_MODE_KEY : r[1:0] == 1 ? BWP_PASS_OPEN : r[1:0] == 2 ? BWP_PASS_CLOSE : r[7:3];
            op(r[11], a, a == CTL_A ? {d[31:8], pw, d[2:0]} : d, {d[11:9], d[8] | d[7]});
        end
        $display("test random done");
        summarize();
    end
    initial
    begin
        #100000;
        fails++;
        summarize();
    end
endmodule : bit_write_protection_lock_tb
`default_nettype wire
